// ===== src/apm_event_mute.sv
// Module: status flags, interrupt ports, section coupling and mute output
`timescale 1ns/1ps
module apm_event_mute
    import apm_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic section_coupling_select, // 0 coupled, 1 independent
    input wire apm_pkg::apm_ev_s tx_events, // Transmit event pulses
    input wire apm_pkg::apm_ev_s rx_events, // Receive event pulses
    input wire apm_pkg::apm_flag_t tx_irq_control, // Transmit enables
    input wire apm_pkg::apm_flag_t rx_irq_control, // Receive enables
    input wire apm_pkg::apm_wr_s tx_status_wr, // Transmit status write
    input wire apm_pkg::apm_wr_s rx_status_wr, // Receive status write
    input wire apm_pkg::apm_fs_in_s tx_fs, // Transmit sync sources
    input wire apm_pkg::apm_fs_in_s rx_fs, // Receive sync sources
    input wire apm_pkg::apm_mute_cfg_s mute_cfg, // Mute configuration
    input wire logic external_mute_input, // Mute request from outside
    output logic [6:0] tx_status_reg, // Transmit status flags
    output logic [6:0] rx_status_reg, // Receive status flags
    output logic tx_irq_port, // Transmit request pulse
    output logic rx_irq_port, // Receive request pulse
    output logic tx_frame_sync_pin_o, // Transmit sync pin value
    output logic tx_frame_sync_pin_oe, // Transmit sync pin drive
    output logic rx_frame_sync_pin_o, // Receive sync pin value
    output logic rx_frame_sync_pin_oe, // Receive sync pin drive
    output logic mute_output // Mute pin level
);
    import apm_pkg::*;

    apm_state_s s_q;
    apm_state_s s_d;
    apm_ev_s ev_v [APM_N_SEC];
    apm_wr_s wr_v [APM_N_SEC];
    apm_flag_t en_v [APM_N_SEC];
    apm_flag_t set_v [APM_N_SEC];
    logic [APM_N_SEC-1:0] sync_v;
    logic [APM_N_SEC-1:0] sof_v;
    logic [APM_N_SEC-1:0] act_v;
    logic coupled;
    logic tx_sync_eff;
    logic rx_sync_own;
    logic ext_act;
    logic mute_act;
    logic [7:0] err_now;

    // Section views so that both ports share one piece of logic
    assign ev_v[APM_SEC_TX] = tx_events;
    assign ev_v[APM_SEC_RX] = rx_events;
    assign wr_v[APM_SEC_TX] = tx_status_wr;
    assign wr_v[APM_SEC_RX] = rx_status_wr;
    assign en_v[APM_SEC_TX] = tx_irq_control;
    assign en_v[APM_SEC_RX] = rx_irq_control;

    // Effective frame syncs; the pin is read back when it is an input
    assign coupled = (section_coupling_select == APM_COUPLED);
    assign tx_sync_eff = tx_fs.sync_dir_out ? tx_fs.sync_gen : tx_fs.sync_pin_i;
    assign rx_sync_own = rx_fs.sync_dir_out ? rx_fs.sync_gen : rx_fs.sync_pin_i;

    // Next state: flags, request ports, sync pins and mute
    always_comb begin
        s_d = s_q;
        sync_v[APM_SEC_TX] = tx_sync_eff;
        if (coupled) begin
            sync_v[APM_SEC_RX] = tx_sync_eff;
        end else begin
            sync_v[APM_SEC_RX] = rx_sync_own;
        end
        for (int i = 0; i < APM_N_SEC; i++) begin
            // Frames start on an edge, not on a level of the sync
            sof_v[i] = sync_v[i] & ~s_q.sync_prev[i];
            s_d.sync_prev[i] = sync_v[i];
            set_v[i] = APM_FLAG_RST;
            set_v[i][APM_BIT_RUN] = ev_v[i].run_err;
            set_v[i][APM_BIT_SYNC] = ev_v[i].sync_err;
            set_v[i][APM_BIT_CLK] = ev_v[i].clk_fail;
            set_v[i][APM_BIT_DMA] = ev_v[i].dma_err;
            set_v[i][APM_BIT_DATA] = ev_v[i].data_ready;
            set_v[i][APM_BIT_LAST] = ev_v[i].data_ready
                & ev_v[i].slot_last;
            set_v[i][APM_BIT_SOF] = sof_v[i];
            // Clear by one, then set, so an event in the clear cycle stays
            if (wr_v[i].wr) begin
                s_d.flags[i] = s_q.flags[i] & ~wr_v[i].wr_data;
            end
            s_d.flags[i] = s_d.flags[i] | set_v[i];
            act_v[i] = |(s_d.flags[i] & en_v[i]);
            // One pulse per service; a write re-arms the port
            s_d.irq[i] = act_v[i]
                & (~s_q.pend[i] | wr_v[i].wr);
            s_d.pend[i] = s_d.irq[i] | (s_q.pend[i] & ~wr_v[i].wr);
        end
        // Transmit sync pin carries the shared sync when it is an output
        s_d.tx_fs_o = tx_fs.sync_gen;
        s_d.tx_fs_oe = tx_fs.sync_dir_out;
        // Receive generator is held off in coupled mode
        s_d.rx_fs_o = coupled ? 1'b0 : rx_fs.sync_gen;
        s_d.rx_fs_oe = ~coupled & rx_fs.sync_dir_out;
        // Mute follows the sticky flags, so it holds until they are cleared
        err_now = {s_d.flags[APM_SEC_RX][APM_ERR_W-1:0],
            s_d.flags[APM_SEC_TX][APM_ERR_W-1:0]};
        ext_act = mute_cfg.ext_en
            & (external_mute_input == mute_cfg.ext_pol);
        mute_act = (|(err_now & mute_cfg.err_en)) | ext_act;
        s_d.mute = mute_act ? mute_cfg.level : ~mute_cfg.level;
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q.flags <= {APM_N_SEC{APM_FLAG_RST}};
            s_q.pend <= '0;
            s_q.irq <= '0;
            s_q.sync_prev <= '0;
            s_q.tx_fs_o <= 1'b0;
            s_q.tx_fs_oe <= 1'b0;
            s_q.rx_fs_o <= 1'b0;
            s_q.rx_fs_oe <= 1'b0;
            s_q.mute <= APM_MUTE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign tx_status_reg = s_q.flags[APM_SEC_TX];
    assign rx_status_reg = s_q.flags[APM_SEC_RX];
    assign tx_irq_port = s_q.irq[APM_SEC_TX];
    assign rx_irq_port = s_q.irq[APM_SEC_RX];
    assign tx_frame_sync_pin_o = s_q.tx_fs_o;
    assign tx_frame_sync_pin_oe = s_q.tx_fs_oe;
    assign rx_frame_sync_pin_o = s_q.rx_fs_o;
    assign rx_frame_sync_pin_oe = s_q.rx_fs_oe;
    assign mute_output = s_q.mute;

    // Checks on the behaviour above
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_tx_irq_enabled;
        tx_irq_port |-> |(tx_status_reg & $past(tx_irq_control));
    endproperty
    a_tx_irq_enabled: assert property (p_tx_irq_enabled)
        else $error("transmit request without an enabled flag");

    property p_rx_irq_enabled;
        rx_irq_port |-> |(rx_status_reg & $past(rx_irq_control));
    endproperty
    a_rx_irq_enabled: assert property (p_rx_irq_enabled)
        else $error("receive request without an enabled flag");

    property p_tx_sof;
        (tx_sync_eff && !s_q.sync_prev[APM_SEC_TX])
            |=> tx_status_reg[APM_BIT_SOF];
    endproperty
    a_tx_sof: assert property (p_tx_sof)
        else $error("transmit frame start not flagged");

    property p_rx_sof_coupled;
        (coupled && tx_sync_eff && !s_q.sync_prev[APM_SEC_RX])
            |=> rx_status_reg[APM_BIT_SOF];
    endproperty
    a_rx_sof_coupled: assert property (p_rx_sof_coupled)
        else $error("receive frame start missed on shared sync");

    property p_tx_last;
        (tx_events.data_ready && tx_events.slot_last)
            |=> tx_status_reg[APM_BIT_LAST] && tx_status_reg[APM_BIT_DATA];
    endproperty
    a_tx_last: assert property (p_tx_last)
        else $error("transmit last slot flag not set");

    property p_rx_last_cause;
        $rose(rx_status_reg[APM_BIT_LAST])
            |-> $past(rx_events.data_ready && rx_events.slot_last);
    endproperty
    a_rx_last_cause: assert property (p_rx_last_cause)
        else $error("receive last slot flag set without cause");

    property p_rx_overrun;
        rx_events.run_err |=> rx_status_reg[APM_BIT_RUN];
    endproperty
    a_rx_overrun: assert property (p_rx_overrun)
        else $error("receive overrun lost");

    property p_tx_clk_fail;
        tx_events.clk_fail |=> tx_status_reg[APM_BIT_CLK];
    endproperty
    a_tx_clk_fail: assert property (p_tx_clk_fail)
        else $error("transmit clock failure lost");

    property p_tx_single_pulse;
        (tx_irq_port && !tx_status_wr.wr) |=> !tx_irq_port;
    endproperty
    a_tx_single_pulse: assert property (p_tx_single_pulse)
        else $error("second transmit pulse while outstanding");

    property p_rx_reissue;
        (rx_status_wr.wr
            && |(rx_status_reg & ~rx_status_wr.wr_data & rx_irq_control))
            |=> rx_irq_port;
    endproperty
    a_rx_reissue: assert property (p_rx_reissue)
        else $error("receive request not reissued after service");

    property p_mute_level;
        mute_act |=> (mute_output == $past(mute_cfg.level));
    endproperty
    a_mute_level: assert property (p_mute_level)
        else $error("mute output not at its active level");

    property p_mute_idle;
        (!mute_cfg.ext_en && !(|(err_now & mute_cfg.err_en)))
            |=> (mute_output != $past(mute_cfg.level));
    endproperty
    a_mute_idle: assert property (p_mute_idle)
        else $error("mute active with no enabled cause");

    property p_rx_pin_off;
        coupled |=> !rx_frame_sync_pin_oe;
    endproperty
    a_rx_pin_off: assert property (p_rx_pin_off)
        else $error("receive sync pin driven in coupled mode");

    property p_tx_pin_shared;
        (coupled && tx_fs.sync_dir_out)
            |=> tx_frame_sync_pin_oe
            && (tx_frame_sync_pin_o == $past(tx_fs.sync_gen));
    endproperty
    a_tx_pin_shared: assert property (p_tx_pin_shared)
        else $error("transmit sync pin does not carry the sync");

    property p_rx_single_pulse;
        (rx_irq_port && !rx_status_wr.wr) |=> !rx_irq_port;
    endproperty
    a_rx_single_pulse: assert property (p_rx_single_pulse)
        else $error("receive request longer than one cycle");

    // Expected from the registered flags, not from the next-state terms
    property p_tx_reissue;
        (tx_status_wr.wr
            && |(tx_status_reg & ~tx_status_wr.wr_data & tx_irq_control))
            |=> tx_irq_port;
    endproperty
    a_tx_reissue: assert property (p_tx_reissue)
        else $error("transmit request not reissued after service");

    property p_tx_run_clear;
        (tx_status_wr.wr && tx_status_wr.wr_data[APM_BIT_RUN]
            && !tx_events.run_err) |=> !tx_status_reg[APM_BIT_RUN];
    endproperty
    a_tx_run_clear: assert property (p_tx_run_clear)
        else $error("transmit underrun not cleared by a one");

    property p_tx_data_hold;
        (tx_status_reg[APM_BIT_DATA]
            && !(tx_status_wr.wr && tx_status_wr.wr_data[APM_BIT_DATA]))
            |=> tx_status_reg[APM_BIT_DATA];
    endproperty
    a_tx_data_hold: assert property (p_tx_data_hold)
        else $error("transmit data ready lost without a clearing one");

    // Mute is registered from the same next flags that the status shows
    property p_rx_err_mute_hold;
        |(rx_status_reg[APM_ERR_W-1:0]
            & $past(mute_cfg.err_en[2*APM_ERR_W-1:APM_ERR_W]))
            |-> (mute_output == $past(mute_cfg.level));
    endproperty
    a_rx_err_mute_hold: assert property (p_rx_err_mute_hold)
        else $error("mute released while an enabled error is set");

    property p_ext_mute;
        (mute_cfg.ext_en && (external_mute_input == mute_cfg.ext_pol))
            |=> (mute_output == $past(mute_cfg.level));
    endproperty
    a_ext_mute: assert property (p_ext_mute)
        else $error("enabled external mute not followed");

    property p_rx_sof_own;
        (!coupled && rx_sync_own && !s_q.sync_prev[APM_SEC_RX])
            |=> rx_status_reg[APM_BIT_SOF];
    endproperty
    a_rx_sof_own: assert property (p_rx_sof_own)
        else $error("receive frame start missed on its own sync");

    // Main scenarios
    c_tx_irq: cover property (tx_irq_port ##[1:20] tx_status_wr.wr);
    c_both_pending: cover property (s_q.pend == 2'b11);
    c_mute_on: cover property (mute_act ##1 mute_output == mute_cfg.level);
    c_coupled_rx_sof: cover property (coupled && sof_v[APM_SEC_RX]);
endmodule

// ===== src/apm_pkg.sv
// Package: constants and carriers for the audio port event and mute logic
package apm_pkg;
    // Section indices; each section owns one status register and one port
    localparam int APM_N_SEC = 2;
    localparam int APM_SEC_TX = 0;
    localparam int APM_SEC_RX = 1;

    // Status and enable bit positions, same layout for both sections
    localparam int APM_FLAG_W = 7;
    localparam int APM_BIT_RUN = 0; // Underrun (tx) or overrun (rx)
    localparam int APM_BIT_SYNC = 1; // Unexpected frame sync
    localparam int APM_BIT_CLK = 2; // Bit clock failure
    localparam int APM_BIT_DMA = 3; // DMA bus error
    localparam int APM_BIT_LAST = 4; // Data ready for the last slot
    localparam int APM_BIT_DATA = 5; // Data ready
    localparam int APM_BIT_SOF = 6; // Start of frame
    localparam int APM_ERR_W = 4; // Error flags sit in bits 3:0

    // Coupling select value that ties receive to the transmit timing
    localparam logic APM_COUPLED = 1'b0;

    // Reset values
    localparam logic [6:0] APM_FLAG_RST = 7'h00;
    localparam logic APM_MUTE_RST = 1'b0;

    typedef logic [APM_FLAG_W-1:0] apm_flag_t;

    // Event pulses from one section's serializer and DMA logic
    typedef struct packed {
        logic data_ready; // Buffer needs service
        logic slot_last; // Qualifies data_ready as last-slot data
        logic run_err; // Underrun or overrun
        logic sync_err; // Unexpected frame sync
        logic clk_fail; // Bit clock failure
        logic dma_err; // DMA bus error
    } apm_ev_s;

    // Software write to a status register
    typedef struct packed {
        logic wr; // Write strobe
        apm_flag_t wr_data; // Ones clear the matching flags
    } apm_wr_s;

    // Frame sync sources of one section
    typedef struct packed {
        logic sync_gen; // Internal frame sync generator output
        logic sync_pin_i; // Level seen on the frame sync pin
        logic sync_dir_out; // Pin configured as output
    } apm_fs_in_s;

    // Mute configuration
    typedef struct packed {
        logic [7:0] err_en; // 3:0 transmit errors, 7:4 receive errors
        logic ext_en; // Honour the external mute input
        logic ext_pol; // Active level of the external mute input
        logic level; // Active level of the mute output
    } apm_mute_cfg_s;

    // Complete state of the block
    typedef struct packed {
        logic [APM_N_SEC-1:0][APM_FLAG_W-1:0] flags;
        logic [APM_N_SEC-1:0] pend; // Request outstanding per port
        logic [APM_N_SEC-1:0] irq; // Request pulse per port
        logic [APM_N_SEC-1:0] sync_prev; // Last effective frame sync
        logic tx_fs_o;
        logic tx_fs_oe;
        logic rx_fs_o;
        logic rx_fs_oe;
        logic mute;
    } apm_state_s;
endpackage

// ===== verif/apm_intc_model.sv
// Interrupt controller stand-in that counts request cycles per port
`timescale 1ns/1ps
module apm_intc_model (
    input wire logic clk, // Bus clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic tx_irq_port, // Transmit request pulse
    input wire logic rx_irq_port, // Receive request pulse
    output logic [7:0] tx_cnt, // Request cycles seen on transmit port
    output logic [7:0] rx_cnt // Request cycles seen on receive port
);
    // Counts high cycles, not edges, so a stretched pulse shows as extra
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_cnt <= 8'h00;
            rx_cnt <= 8'h00;
        end else begin
            tx_cnt <= tx_cnt + 8'(tx_irq_port);
            rx_cnt <= rx_cnt + 8'(rx_irq_port);
        end
    end
endmodule

// ===== verif/apm_event_mute_bench.sv
// Self-checking bench for the event, interrupt and mute logic
`timescale 1ns/1ps
module apm_event_mute_bench
    import apm_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sel = 1'b1;
    logic ext_in = 1'b0;
    apm_ev_s tx_ev = '0;
    apm_ev_s rx_ev = '0;
    apm_flag_t tx_en = '0;
    apm_flag_t rx_en = '0;
    apm_wr_s tx_wr = '0;
    apm_wr_s rx_wr = '0;
    apm_fs_in_s tx_fs = '0;
    apm_fs_in_s rx_fs = '0;
    apm_mute_cfg_s mcfg = '{8'h00, 1'b0, 1'b1, 1'b1};
    logic [6:0] tx_st, rx_st;
    logic tx_irq, rx_irq, tx_o, tx_oe, rx_o, rx_oe, mute;
    logic [7:0] tx_cnt, rx_cnt, tb;
    int bad_count = 0;
    int n_compared = 0;

    always #4 clk = ~clk;

    apm_event_mute apm_event_mute_inst (
        .clk(clk), .sys_rst(sys_rst), .section_coupling_select(sel),
        .tx_events(tx_ev), .rx_events(rx_ev), .tx_irq_control(tx_en),
        .rx_irq_control(rx_en), .tx_status_wr(tx_wr), .rx_status_wr(rx_wr),
        .tx_fs(tx_fs), .rx_fs(rx_fs), .mute_cfg(mcfg),
        .external_mute_input(ext_in), .tx_status_reg(tx_st),
        .rx_status_reg(rx_st), .tx_irq_port(tx_irq), .rx_irq_port(rx_irq),
        .tx_frame_sync_pin_o(tx_o), .tx_frame_sync_pin_oe(tx_oe),
        .rx_frame_sync_pin_o(rx_o), .rx_frame_sync_pin_oe(rx_oe),
        .mute_output(mute));

    apm_intc_model apm_intc_model_inst (.clk(clk), .sys_rst(sys_rst),
        .tx_irq_port(tx_irq), .rx_irq_port(rx_irq),
        .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle event pulse on both sections at once
    task automatic ev(input apm_ev_s t, input apm_ev_s r);
        tx_ev = t;
        rx_ev = r;
        step(1);
        tx_ev = '0;
        rx_ev = '0;
    endtask

    task automatic wr(input apm_wr_s t, input apm_wr_s r);
        tx_wr = t;
        rx_wr = r;
        step(1);
        tx_wr = '0;
        rx_wr = '0;
    endtask

    // Error events set their flags even with every enable low
    task automatic t_err_flags;
        tb = tx_cnt;
        for (int i = 0; i < 4; i++) begin
            ev(6'(1 << (3 - i)), 6'(1 << (3 - i)));
            chk("tx error flag", 8'(1 << i), 8'(tx_st));
            chk("rx error flag", 8'(1 << i), 8'(rx_st));
            wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
            chk("tx cleared", 8'h00, 8'(tx_st));
        end
        step(1);
        chk("no tx pulse", tb, tx_cnt);
    endtask

    // Pulse, outstanding hold-off and re-request after a status write
    task automatic t_irq;
        tx_en = 7'h21;
        rx_en = 7'h20;
        tb = tx_cnt;
        ev(6'h20, 6'h00);
        step(1);
        chk("tx pulse", tb + 8'd1, tx_cnt);
        ev(6'h08, 6'h20);
        step(1);
        chk("held off", tb + 8'd1, tx_cnt);
        chk("rx pulse", 8'd1, rx_cnt);
        wr('{1'b1, 7'h00}, '{1'b1, 7'h20});
        chk("zero write", 8'h21, 8'(tx_st));
        step(1);
        chk("re-request", tb + 8'd2, tx_cnt);
        chk("rx quiet", 8'd1, rx_cnt);
        wr('{1'b1, 7'h20}, '0);
        chk("partial clear", 8'h01, 8'(tx_st));
        step(1);
        chk("still active", tb + 8'd3, tx_cnt);
        wr('{1'b1, 7'h01}, '0);
        tx_en = 7'h00;
        ev(6'h20, 6'h00);
        step(1);
        chk("disabled", tb + 8'd3, tx_cnt);
        tx_en = 7'h20;
        step(2);
        chk("enable rise", tb + 8'd4, tx_cnt);
        wr('{1'b1, 7'h7f}, '0);
    endtask

    // Many flags in one cycle give one pulse on each port
    task automatic t_simul;
        tx_en = 7'h7f;
        rx_en = 7'h7f;
        tb = tx_cnt;
        ev(6'h2f, 6'h2f);
        step(2);
        chk("tx single", tb + 8'd1, tx_cnt);
        chk("rx single", 8'd2, rx_cnt);
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
        tx_en = 7'h00;
        rx_en = 7'h00;
    endtask

    // Last-slot flag only with data ready in the same cycle
    task automatic t_last;
        ev(6'h30, 6'h30);
        chk("tx last", 8'h30, 8'(tx_st));
        chk("rx last", 8'h30, 8'(rx_st));
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
        ev(6'h10, 6'h20);
        chk("tx lone qualifier", 8'h00, 8'(tx_st));
        chk("rx data only", 8'h20, 8'(rx_st));
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
    endtask

    // Coupled sections share the transmit sync; independent ones do not
    task automatic t_sync;
        sel = APM_COUPLED;
        rx_fs = '{1'b1, 1'b1, 1'b1};
        step(1);
        chk("rx sync ignored", 8'h00, 8'(rx_st));
        chk("rx pin off", 8'h00, 8'({rx_o, rx_oe}));
        tx_fs = '{1'b1, 1'b0, 1'b1};
        step(1);
        chk("tx sof", 8'h40, 8'(tx_st));
        chk("rx sof", 8'h40, 8'(rx_st));
        chk("tx pin", 8'h03, 8'({tx_o, tx_oe}));
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
        tx_fs = '0;
        step(2);
        sel = ~APM_COUPLED;
        step(1);
        chk("rx own sof", 8'h40, 8'(rx_st));
        chk("tx no sof", 8'h00, 8'(tx_st));
        chk("rx pin", 8'h03, 8'({rx_o, rx_oe}));
        rx_fs = '0;
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
        // Sync taken from the pin when it is an input
        tx_fs = '{1'b0, 1'b1, 1'b0};
        step(1);
        chk("tx pin sof", 8'h40, 8'(tx_st));
        chk("rx apart", 8'h00, 8'(rx_st));
        chk("tx pin idle", 8'h00, 8'({tx_o, tx_oe}));
        tx_fs = '0;
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
    endtask

    // Mute from enabled errors and the external input
    task automatic t_mute;
        mcfg = '{8'h10, 1'b0, 1'b1, 1'b1};
        ext_in = 1'b1;
        ev(6'h08, 6'h00);
        chk("input off, tx err", 8'h00, 8'(mute));
        ev(6'h00, 6'h08);
        chk("rx err mutes", 8'h01, 8'(mute));
        mcfg.ext_en = 1'b1;
        wr('{1'b1, 7'h7f}, '{1'b1, 7'h7f});
        chk("input holds", 8'h01, 8'(mute));
        ext_in = 1'b0;
        step(1);
        chk("released", 8'h00, 8'(mute));
        mcfg.ext_pol = 1'b0;
        step(1);
        chk("low polarity", 8'h01, 8'(mute));
        mcfg.level = 1'b0;
        step(1);
        chk("low level", 8'h00, 8'(mute));
        ext_in = 1'b1;
        step(1);
        chk("inactive high", 8'h01, 8'(mute));
    endtask

    task automatic end_sim;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog so a stuck sequence still reaches the verdict
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        step(20);
        sys_rst = 1'b0;
        step(2);
        t_err_flags();
        t_irq();
        t_simul();
        t_last();
        t_sync();
        t_mute();
        end_sim();
    end
endmodule
